// File: pkg/aswa_map.vh
// Register offsets, field positions and timing for the serial wakeup and bit timer block.
// Assumes a 32-bit AXI4-Lite bus with byte addresses.
`ifndef ASWA_MAP_VH
`define ASWA_MAP_VH

// Register byte addresses
`define ASWA_CTL_OFS 8'h00
`define ASWA_CNT_OFS 8'h04
`define ASWA_SER_OFS 8'h08
`define ASWA_DAT_OFS 8'h0c
`define ASWA_IST_OFS 8'h10
`define ASWA_ICL_OFS 8'h14
`define ASWA_IEN_OFS 8'h18

// Bit timer control fields
`define ASWA_CTL_MLO 0
`define ASWA_CTL_MHI 1
`define ASWA_CTL_CLK 2
`define ASWA_CTL_DONE 3
`define ASWA_CTL_RUN 4
`define ASWA_CTL_LOST 5
`define ASWA_CTL_OVF 6
`define ASWA_CTL_MSB 7

// Serial control fields
`define ASWA_SER_STBY 0
`define ASWA_SER_WAKE 1
`define ASWA_SER_IDLE_COUNT_SELECT 2
`define ASWA_SER_FULL 3
`define ASWA_SER_IDLE 4

// Interrupt status fields
`define ASWA_IRQ_FULL 0
`define ASWA_IRQ_IDLE 1
`define ASWA_IRQ_DONE 2
`define ASWA_IRQ_LOST 3
`define ASWA_IRQ_OVF 4

// Arbitration sample points
`define ASWA_ARB_PT0 9'h038
`define ASWA_ARB_PT1 9'h008

// Receiver oversampling and character length
`define ASWA_OVS 16
`define ASWA_CHAR_BITS 10
`endif

// File: src/aswa_top.v
// Receiver wakeup and 9-bit bit timer / arbitration counter of an async serial port.
// Assumes a single 100 MHz clock, AXI4-Lite slave, a serial prescaler tick input
// from the same clock domain, and an asynchronous receive pin.
`timescale 1ns/10ps
`include "aswa_map.vh"

module aswa_top #(
  parameter OVS = `ASWA_OVS // Receiver samples per bit
) (
  input wire clock, // 100 MHz clock
  input wire rst, // Synchronous reset, active high
  input wire rx_pin, // Receive pin, asynchronous
  input wire internal_serial_out, // Transmitter output, same domain
  input wire presc_tick, // Serial prescaler clock enable pulse
  input wire rx_tick, // Receiver oversample tick, OVS per bit
  input wire [3:0] s_axi_awaddr_lo_unused, // Unused spare, tie low
  input wire [7:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [7:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  output reg tx_pin, // Transmit pin
  output reg irq // Level interrupt
);

  // Receiver states
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_STOP = 2'd3;

  // Two-stage synchroniser on the receive pin
  reg rx_s1_ff, rx_s2_ff, rx_prev_ff;
  always @(posedge clock) begin
    if (rst) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_s1_ff <= rx_pin;
      rx_s2_ff <= rx_s1_ff;
      rx_prev_ff <= rx_s2_ff;
    end
  end
  wire rx_fall = rx_prev_ff & ~rx_s2_ff; // Falling edge, synced
  wire rx_rise = ~rx_prev_ff & rx_s2_ff; // Rising edge, synced

  // Software state
  reg [2:0] ctl_ff; // Mode lo, mode hi, clock select
  reg standby_request_ff, wake_ff, idle_count_select_ff;
  reg receive_full_flag_ff, idle_flag_ff;
  reg [7:0] rx_data_ff;
  reg [4:0] ist_ff, ien_ff;

  // Counter state
  reg [8:0] cnt_ff;
  reg counter_running_flag_ff, measurement_done_flag_ff;
  reg arbitration_lost_flag_ff, counter_overflow_flag_ff;
  reg [1:0] div_ff; // Clock divider for counter tick
  reg tx_prev_ff;

  // AXI bookkeeping
  reg aw_hold_ff, w_hold_ff;
  reg [7:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;

  // Write is performed once address and data are both held
  wire wr_go = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  wire wr_ctl = wr_go & (aw_addr_ff == `ASWA_CTL_OFS) & w_strb_ff[0];
  wire wr_ser = wr_go & (aw_addr_ff == `ASWA_SER_OFS) & w_strb_ff[0];
  wire wr_icl = wr_go & (aw_addr_ff == `ASWA_ICL_OFS) & w_strb_ff[0];
  wire wr_ien = wr_go & (aw_addr_ff == `ASWA_IEN_OFS) & w_strb_ff[0];
  wire [1:0] mode = ctl_ff[1:0];
  wire aclk = ctl_ff[2];

  // Counter tick: quarter clock for select 0, half of prescaler for select 1
  // quarter bus clock
  wire cnt_tick = aclk ? (presc_tick & div_ff[0]) : (div_ff == 2'b11);
  always @(posedge clock) begin
    if (rst) div_ff <= 2'b00;
    else if (aclk) div_ff <= presc_tick ? div_ff + 2'b01 : div_ff;
    else div_ff <= div_ff + 2'b01;
  end

  // Receiver, keeps framing even in standby
  reg [1:0] rx_st_ff;
  reg [4:0] rx_ph_ff; // Oversample phase
  reg [3:0] rx_bit_ff; // Bit index
  reg [7:0] rx_sh_ff;
  reg [4:0] ones_ff; // Consecutive one counter, in bits
  reg idle_seen_ff; // Idle already reported since last character
  wire mid = rx_tick & (rx_ph_ff == OVS / 2 - 1);
  wire ph_end = rx_tick & (rx_ph_ff == OVS - 1);
  reg char_done, char_msb;
  reg idle_det;

  // Receiver framing and idle counting
  // framing in standby
  always @(posedge clock) begin
    if (rst) begin
      rx_st_ff <= RX_IDLE;
      rx_ph_ff <= 5'd0;
      rx_bit_ff <= 4'd0;
      rx_sh_ff <= 8'h00;
      ones_ff <= 5'd0;
      idle_seen_ff <= 1'b1;
    end else begin
      if (rx_tick) rx_ph_ff <= ph_end ? 5'd0 : rx_ph_ff + 5'd1;
      // One bit time of line high counts toward idle
      if (ph_end) begin
        if (!rx_s2_ff) ones_ff <= 5'd0;
        else if (ones_ff != 5'd31) ones_ff <= ones_ff + 5'd1;
      end
      if (idle_det) idle_seen_ff <= 1'b1;
      case (rx_st_ff)
        RX_IDLE: begin
          if (rx_fall) begin
            rx_st_ff <= RX_START;
            rx_ph_ff <= 5'd0;
            idle_seen_ff <= 1'b0;
          end
        end
        RX_START: begin
          if (mid) begin
            rx_st_ff <= rx_s2_ff ? RX_IDLE : RX_DATA;
            rx_bit_ff <= 4'd0;
            if (!idle_count_select_ff) ones_ff <= 5'd0;
          end
        end
        RX_DATA: begin
          if (mid) begin
            rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 4'd1;
            if (rx_bit_ff == 4'd7) rx_st_ff <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (mid) begin
            rx_st_ff <= RX_IDLE;
            if (idle_count_select_ff) ones_ff <= 5'd0;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // Character and idle events
  always @* begin
    char_done = (rx_st_ff == RX_STOP) & mid & rx_s2_ff;
    char_msb = rx_sh_ff[7];
    idle_det = ~idle_seen_ff & (ones_ff >= `ASWA_CHAR_BITS) & (rx_st_ff == RX_IDLE);
  end

  // Wakeup: address mark or idle ends standby
  wire wake_addr = standby_request_ff & wake_ff & char_done & char_msb;
  wire wake_idle = standby_request_ff & ~wake_ff & idle_det;
  wire ev_full = char_done & (~standby_request_ff | wake_addr);
  wire ev_idle = idle_det & ~standby_request_ff;

  // Serial control and receive flags; flag set wins over clear by write
  always @(posedge clock) begin
    if (rst) begin
      standby_request_ff <= 1'b0;
      wake_ff <= 1'b0;
      idle_count_select_ff <= 1'b0;
      receive_full_flag_ff <= 1'b0;
      idle_flag_ff <= 1'b0;
      rx_data_ff <= 8'h00;
    end else begin
      if (wr_ser) begin
        standby_request_ff <= w_data_ff[`ASWA_SER_STBY];
        wake_ff <= w_data_ff[`ASWA_SER_WAKE];
        idle_count_select_ff <= w_data_ff[`ASWA_SER_IDLE_COUNT_SELECT];
        receive_full_flag_ff <= receive_full_flag_ff & w_data_ff[`ASWA_SER_FULL];
        idle_flag_ff <= idle_flag_ff & w_data_ff[`ASWA_SER_IDLE];
      end
      if (wake_addr | wake_idle) standby_request_ff <= 1'b0;
      if (ev_full) begin
        receive_full_flag_ff <= 1'b1;
        rx_data_ff <= rx_sh_ff;
      end
      if (ev_idle) idle_flag_ff <= 1'b1;
    end
  end

  // Bit timer counter, modes and arbitration
  wire tx_rise = ~tx_prev_ff & internal_serial_out;
  wire [8:0] arb_pt = aclk ? `ASWA_ARB_PT1 : `ASWA_ARB_PT0;
  reg ev_done, ev_lost, ev_ovf;
  always @(posedge clock) begin
    if (rst) begin
      cnt_ff <= 9'h000;
      counter_running_flag_ff <= 1'b0;
      measurement_done_flag_ff <= 1'b0;
      arbitration_lost_flag_ff <= 1'b0;
      counter_overflow_flag_ff <= 1'b0;
      tx_prev_ff <= 1'b1;
      ev_done <= 1'b0;
      ev_lost <= 1'b0;
      ev_ovf <= 1'b0;
    end else begin
      tx_prev_ff <= internal_serial_out;
      ev_done <= 1'b0;
      ev_lost <= 1'b0;
      ev_ovf <= 1'b0;
      if (wr_ctl) begin
        cnt_ff <= 9'h000;
        counter_overflow_flag_ff <= 1'b0;
        counter_running_flag_ff <= 1'b0;
        measurement_done_flag_ff <= 1'b0;
        arbitration_lost_flag_ff <= 1'b0;
      end else if (mode == 2'b00) begin
        cnt_ff <= 9'h000;
        counter_running_flag_ff <= 1'b0;
      end else if (mode == 2'b10) begin
        if (tx_rise) begin
          cnt_ff <= 9'h000;
          counter_running_flag_ff <= 1'b1;
        end else if (counter_running_flag_ff & cnt_tick) begin
          cnt_ff <= cnt_ff + 9'h001;
          if (cnt_ff + 9'h001 == arb_pt) begin
            counter_running_flag_ff <= 1'b0;
            if (!rx_s2_ff) begin
              arbitration_lost_flag_ff <= 1'b1;
              ev_lost <= 1'b1;
            end
          end
        end
      end else if (!measurement_done_flag_ff) begin
        if (!counter_running_flag_ff) begin
          if (aclk ? ~rx_s2_ff : rx_fall) counter_running_flag_ff <= 1'b1;
        end else if (aclk ? rx_rise : rx_fall) begin
          counter_running_flag_ff <= 1'b0;
          measurement_done_flag_ff <= 1'b1;
          ev_done <= 1'b1;
        end else if (cnt_tick) begin
          cnt_ff <= cnt_ff + 9'h001;
        end
      end
      if (!wr_ctl && mode != 2'b00 && counter_running_flag_ff && cnt_tick
          && cnt_ff == 9'h1ff) begin
        counter_overflow_flag_ff <= 1'b1;
        ev_ovf <= 1'b1;
      end
    end
  end

  // Transmit pin, forced high while arbitration is lost
  always @(posedge clock) begin
    if (rst) tx_pin <= 1'b1;
    else tx_pin <= internal_serial_out | arbitration_lost_flag_ff;
  end

  // Control register, sticky interrupt status, enables
  always @(posedge clock) begin
    if (rst) begin
      ctl_ff <= 3'b000;
      ist_ff <= 5'h00;
      ien_ff <= 5'h00;
      irq <= 1'b0;
    end else begin
      if (wr_ctl) ctl_ff <= w_data_ff[2:0];
      if (wr_ien) ien_ff <= w_data_ff[4:0];
      // Set wins over clear in the same cycle
      ist_ff <= (ist_ff & ~(wr_icl ? w_data_ff[4:0] : 5'h00))
        | {ev_ovf, ev_lost, ev_done, ev_idle, ev_full};
      irq <= |(ist_ff & ien_ff);
    end
  end

  // AXI write channel: accept address and data in either order
  always @(posedge clock) begin
    if (rst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= ~aw_hold_ff & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_hold_ff & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        // Unmapped or read-only offsets answer with slave error
        s_axi_bresp <= (aw_addr_ff == `ASWA_CTL_OFS || aw_addr_ff == `ASWA_SER_OFS
          || aw_addr_ff == `ASWA_ICL_OFS || aw_addr_ff == `ASWA_IEN_OFS) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
      end
    end
  end

  // AXI read channel, one read at a time
  always @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case ({s_axi_araddr[7:2], 2'b00})
          `ASWA_CTL_OFS: s_axi_rdata <= {24'h000000, cnt_ff[8], counter_overflow_flag_ff,
            arbitration_lost_flag_ff, counter_running_flag_ff, measurement_done_flag_ff,
            ctl_ff};
          `ASWA_CNT_OFS: s_axi_rdata <= {24'h000000, cnt_ff[7:0]};
          `ASWA_SER_OFS: s_axi_rdata <= {27'h0000000, idle_flag_ff, receive_full_flag_ff,
            idle_count_select_ff, wake_ff, standby_request_ff};
          `ASWA_DAT_OFS: s_axi_rdata <= {24'h000000, rx_data_ff};
          `ASWA_IST_OFS: s_axi_rdata <= {27'h0000000, ist_ff};
          `ASWA_ICL_OFS: s_axi_rdata <= 32'h0000_0000;
          `ASWA_IEN_OFS: s_axi_rdata <= {27'h0000000, ien_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // aswa_top

// File: verification/aswa_top_assertions.sv
// Checker for the serial wakeup and bit timer block.
// Assumes one clock, sync reset, and sight of the top-level ports only.
`timescale 1ns/10ps
`include "aswa_map.vh"
module aswa_chk (
  input wire clock, // Clock
  input wire rst, // Sync reset
  input wire internal_serial_out, // Transmit source
  input wire [7:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  input wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire s_axi_wvalid, // Write data valid
  input wire s_axi_wready, // Write data ready
  input wire [1:0] s_axi_bresp, // Write response
  input wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [7:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  input wire s_axi_arready, // Read address ready
  input wire [31:0] s_axi_rdata, // Read data
  input wire [1:0] s_axi_rresp, // Read response
  input wire s_axi_rvalid, // Read valid
  input wire tx_pin, // Transmit pin
  input wire irq // Interrupt
);
  reg [7:0] wa_ff; // Last write address
  reg [7:0] wd_ff; // Last write data byte
  reg [7:0] ra_ff; // Last read address
  reg [7:0] en_ff; // Shadow of interrupt enable
  reg [1:0] mode_ff; // Shadow of counter mode
  wire rd_ctl = s_axi_rvalid && ra_ff == `ASWA_CTL_OFS; // Control read answered
  // Shadows follow only accepted writes, so a refused write leaves them alone
  always @(posedge clock) begin
    if (rst) begin
      wa_ff <= 8'h00;
      wd_ff <= 8'h00;
      ra_ff <= 8'h00;
      en_ff <= 8'h00;
      mode_ff <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata[7:0];
      if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0) begin
        if (wa_ff == `ASWA_IEN_OFS) en_ff <= wd_ff;
        if (wa_ff == `ASWA_CTL_OFS) mode_ff <= wd_ff[1:0];
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_tx_follow: assert property (internal_serial_out |=> tx_pin)
    else $error("tx pin low after high source");
  chk_tx_source: assert property (!tx_pin |-> !$past(internal_serial_out))
    else $error("tx pin low without low source");
  chk_lost_tx: assert property (rd_ctl && s_axi_rdata[5] |-> tx_pin)
    else $error("tx pin not forced while lost");
  chk_lost_mode: assert property (rd_ctl && s_axi_rdata[5] |-> s_axi_rdata[1:0] == 2'h2)
    else $error("lost flag outside arbitration");
  chk_done_run: assert property (rd_ctl |-> !(s_axi_rdata[3] && s_axi_rdata[4]))
    else $error("done and running together");
  chk_ovf_mode: assert property (rd_ctl && s_axi_rdata[6] |-> s_axi_rdata[1:0] != 2'h0)
    else $error("overflow while counter held");
  chk_idle_ctl: assert property (rd_ctl && s_axi_rdata[1:0] == 2'h0 |-> s_axi_rdata[7:3] == 5'h00)
    else $error("held counter shows flags");
  chk_idle_cnt: assert property (s_axi_rvalid && ra_ff == `ASWA_CNT_OFS && mode_ff == 2'h0
    |-> s_axi_rdata == 32'h0)
    else $error("held counter not zero");
  chk_irq_mask: assert property (en_ff == 8'h00 [*4] |-> !irq)
    else $error("irq with nothing enabled");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:4] s_axi_bvalid)
    else $error("write not answered");
  cover property (rd_ctl && s_axi_rdata[5]);
  cover property (rd_ctl && s_axi_rdata[3]);
  cover property ($rose(irq));
endmodule // aswa_chk
bind aswa_top aswa_chk aswa_chk_i (.clock(clock), .rst(rst),
  .internal_serial_out(internal_serial_out), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .tx_pin(tx_pin), .irq(irq));

// File: verification/aswa_node.sv
// Remote serial node driving the receive line of the block.
// Assumes one bit lasts BIT_CLKS clocks, i.e. 16 receiver ticks.
`timescale 1ns/10ps
module aswa_node #(
  parameter BIT_CLKS = 16 // Clocks per bit
) (
  input wire clock, // Bench clock
  output logic line // Receive line, idles high
);
  initial line = 1'b1;
  // Hold one level; changes land just after an edge
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clock);
  endtask
  // Start bit, eight data bits LSB first, one stop bit
  task automatic send(input logic [7:0] b);
    hold(1'b0, BIT_CLKS);
    for (int i = 0; i < 8; i++) hold(b[i], BIT_CLKS);
    hold(1'b1, BIT_CLKS);
  endtask
endmodule // aswa_node

// File: verification/aswa_top_tb.sv
// Self-checking bench for the serial wakeup and bit timer block.
// Assumes the remote node model and the bound checker.
`timescale 1ns/10ps
`include "aswa_map.vh"
module aswa_top_tb;
  localparam logic [7:0] CTL = `ASWA_CTL_OFS, CNT = `ASWA_CNT_OFS, SER = `ASWA_SER_OFS,
    DAT = `ASWA_DAT_OFS, IST = `ASWA_IST_OFS, ICL = `ASWA_ICL_OFS, IEN = `ASWA_IEN_OFS;
  logic clock = 0, rst = 1, isout = 0, presc = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic bready = 0, rready = 0; // Response takers, up only while an answer is awaited
  logic [3:0] wstrb = 4'hf; // Write strobes, lowered only by the strobe scenario
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [1:0] r;
  wire rx, awready, wready, bvalid, arready, rvalid, tx_pin, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int n_mismatch = 0, num_checks = 0;
  always #5 clock = ~clock;
  // Prescaler tick every second clock
  always @(posedge clock) presc <= ~presc;
  aswa_node aswa_node_i (.clock(clock), .line(rx));
  aswa_top aswa_top_i (.clock(clock), .rst(rst), .rx_pin(rx), .internal_serial_out(isout),
    .presc_tick(presc), .rx_tick(1'b1), .s_axi_awaddr_lo_unused(4'h0), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_pin(tx_pin), .irq(irq));
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // A wait that ran out ends the run as a failure
  task automatic tmo(input int i);
    if (i == 50) begin
      n_mismatch++;
      $display("[ERR] bus wait exp answer got none");
      complete_run();
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int i;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(i);
    // One edge between calls, so the next call never raises bready in this step
    @(posedge clock);
  endtask
  // Read: data and response taken at the edge rvalid is seen
  task automatic axr(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(i);
    @(posedge clock);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    axr(a);
    cmp(nm, e, d & m);
  endtask
  task automatic s_regs();
    rchk("ctl reset", CTL, 32'hff, 32'h0);
    rchk("cnt reset", CNT, 32'hff, 32'h0);
    axr(8'h40);
    cmp("unmapped resp", 32'h2, r);
    axw(CNT, 32'h5);
    cmp("ro write resp", 32'h2, r);
    // A write with its low strobe off must leave the register alone
    wstrb <= 4'h0;
    axw(SER, 32'h7);
    wstrb <= 4'hf;
    rchk("strobe off", SER, 32'h7, 32'h0);
  endtask
  task automatic s_addr_wake();
    axw(ICL, 32'h1f);
    axw(IEN, 32'h1);
    axw(SER, 32'h3);
    aswa_node_i.send(8'h55);
    rchk("still standby", SER, 32'h1, 32'h1);
    cmp("irq in standby", 32'h0, irq);
    aswa_node_i.send(8'ha5);
    aswa_node_i.hold(1'b1, 20);
    rchk("address wake", SER, 32'h9, 32'h8);
    rchk("address byte", DAT, 32'hff, 32'ha5);
    cmp("irq raised", 32'h1, irq);
    axw(IEN, 32'h0);
    repeat (2) @(posedge clock);
    cmp("irq masked", 32'h0, irq);
  endtask
  // Idle wake, counting from start bit and from stop bit
  task automatic s_idle_wake();
    for (int i = 0; i < 2; i++) begin
      axw(ICL, 32'h1f);
      axw(SER, 32'h1 | (i << 2));
      aswa_node_i.send(8'hff);
      aswa_node_i.hold(1'b1, 64);
      rchk("idle count start", SER, 32'h1, i);
      aswa_node_i.hold(1'b1, 128);
      rchk("idle wake", SER, 32'h19, 32'h0);
      rchk("idle status", IST, 32'h3, 32'h0);
    end
  endtask
  // Falling edges 400 clocks apart at a quarter clock
  task automatic s_bit_time();
    axw(CTL, 32'h1);
    fork
      begin
        aswa_node_i.hold(1'b0, 40);
        aswa_node_i.hold(1'b1, 360);
        aswa_node_i.hold(1'b0, 20);
      end
      begin
        repeat (150) @(posedge clock);
        rchk("running", CTL, 32'h18, 32'h10);
      end
    join
    aswa_node_i.hold(1'b1, 20);
    rchk("done", CTL, 32'h18, 32'h8);
    axr(CNT);
    cmp("bit count", 32'h1, d >= 99 && d <= 101);
  endtask
  // Line already low at enable; prescaler tick every 2 clocks
  task automatic s_break();
    aswa_node_i.hold(1'b0, 4);
    axw(CTL, 32'h5);
    aswa_node_i.hold(1'b0, 400);
    aswa_node_i.hold(1'b1, 10);
    rchk("break done", CTL, 32'h18, 32'h8);
    axr(CNT);
    cmp("break count", 32'h1, d >= 99 && d <= 102);
  endtask
  task automatic s_ovf();
    axw(IEN, 32'h10);
    aswa_node_i.hold(1'b0, 4);
    // Mode 11 measures like mode 01
    axw(CTL, 32'h7);
    aswa_node_i.hold(1'b0, 2100);
    rchk("overflow", CTL, 32'h40, 32'h40);
    cmp("irq overflow", 32'h1, irq);
    axw(ICL, 32'h10);
    repeat (2) @(posedge clock);
    cmp("irq cleared", 32'h0, irq);
    axw(CTL, 32'h0);
    rchk("ctl cleared", CTL, 32'hff, 32'h0);
    aswa_node_i.hold(1'b0, 40);
    rchk("held count", CNT, 32'hff, 32'h0);
    aswa_node_i.hold(1'b1, 4);
  endtask
  // Line drops just before or just after the sample point
  task automatic s_arb();
    int t;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 2; k++) begin
        t = c ? 32 : 224;
        axw(CTL, (c << 2) | 2);
        isout <= 1'b1;
        aswa_node_i.hold(1'b1, k ? t - 12 : t + 20);
        aswa_node_i.hold(1'b0, 60);
        isout <= 1'b0;
        aswa_node_i.hold(1'b1, 4);
        rchk("arb lost", CTL, 32'h20, k << 5);
        cmp("tx forced", k, tx_pin);
      end
    end
  endtask
  // Reset in mid-run, while the last arbitration still holds the lost flag
  task automatic s_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    cmp("tx after reset", 32'h0, tx_pin);
    rchk("ctl after reset", CTL, 32'hff, 32'h0);
    rchk("cnt after reset", CNT, 32'hff, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    s_regs();
    s_addr_wake();
    s_idle_wake();
    s_bit_time();
    s_break();
    s_ovf();
    s_arb();
    s_reset();
    complete_run();
  end
endmodule // aswa_top_tb
